// ==== bench/cars_core_sva.sv ====
/*
 assertions on the stack port of the addressing block.
 assumes bind to cars_core; push and pop never coincide.
*/
`timescale 1ns/1ps
module cars_core_sva (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // stack port
   input wire logic push,
   input wire logic pop,
   input wire logic [15:0] push_pc,
   input wire logic [15:0] pop_pc,
   input wire logic stack_space_flag
);
   // ------------------
   // reference stack
   // ------------------
   logic [3:0] ptr;
   logic locked;
   logic [15:0] wr;
   logic [15:0] exp_pop;
   logic [15:0] mem [16];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr <= 4'h0;
         locked <= 1'b0;
         wr <= 16'h0000;
         exp_pop <= 16'h0000;
      end else if (push) begin
         ptr <= ptr + 4'h1;
         wr[ptr] <= 1'b1;
         locked <= locked | (ptr == 4'hF);
      end else if (pop) begin
         ptr <= ptr - 4'h1;
         exp_pop <= mem[ptr - 4'h1];
      end
   end
   always_ff @(posedge hclk) begin
      if (push) begin
         mem[ptr] <= push_pc;
      end
   end
   // ------------------
   // properties
   // ------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_FLAG_RESET: assert property ($rose(hresetn) |-> stack_space_flag)
      else $error("flag low after reset");
   AST_FLAG_TOP: assert property (push && ptr == 4'hE |=> !stack_space_flag)
      else $error("flag set with pointer at top");
   AST_FLAG_QUIET: assert property (!push && !pop |=> $stable(stack_space_flag))
      else $error("flag moved without stack activity");
   AST_FLAG_BACK: assert property (pop && ptr == 4'hF && !locked |=> stack_space_flag)
      else $error("flag not restored below top");
   AST_WRAP_LOCK: assert property (push && ptr == 4'hF |=> !stack_space_flag [*2])
      else $error("flag set after wrap");
   AST_LOCKED: assert property (locked |-> !stack_space_flag)
      else $error("flag set while locked");
   AST_POP_FIRST: assert property (pop && ptr == 4'h0 |=> !stack_space_flag)
      else $error("flag set after pop at zero");
   AST_POP_DATA: assert property (pop && wr[ptr - 4'h1] |=> pop_pc == exp_pop)
      else $error("popped value wrong");
   AST_POP_HOLD: assert property (!pop |=> $stable(pop_pc))
      else $error("popped value moved without pop");
endmodule

// ==== bench/cars_seq_model.sv ====
/*
 instruction sequencer model: call and return strobes.
 assumes tasks are entered just after a rising clock edge.
*/
`timescale 1ns/1ps
module cars_seq_model (
   // clock
   input wire logic hclk,
   // stack strobes
   output logic push,
   output logic pop,
   output logic [15:0] push_pc
);
   initial begin
      push = 1'b0;
      pop = 1'b0;
      push_pc = 16'h0000;
   end
   // one-cycle call pulse, pc scrambled after
   task automatic do_push(input logic [15:0] pc);
      push <= 1'b1;
      push_pc <= pc;
      @(posedge hclk);
      push <= 1'b0;
      push_pc <= ~pc;
      @(posedge hclk);
   endtask
   // one-cycle return pulse
   task automatic do_pop();
      pop <= 1'b1;
      @(posedge hclk);
      pop <= 1'b0;
      @(posedge hclk);
   endtask
endmodule

// ==== bench/tb_cars_core.sv ====
/*
 testbench for cars_core: stack, indirect windows, banks, interrupt.
 assumes ahb-lite slave that waits one cycle on data-space reads.
*/
`timescale 1ns/1ps
module tb_cars_core;
   logic hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hreadyout, hresp, irq, push, pop, stack_space_flag;
   wire logic [31:0] hrdata;
   wire logic [15:0] push_pc, pop_pc;
   int n_errors = 0;
   int checks_done = 0;
   cars_core cars_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .push(push), .pop(pop),
      .push_pc(push_pc), .pop_pc(pop_pc), .stack_space_flag(stack_space_flag), .irq(irq));
   cars_seq_model cars_seq_model_i (.hclk(hclk), .push(push), .pop(pop), .push_pc(push_pc));
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // ----------------
   // helpers
   // ----------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= cars_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0000_0000);
      chk("hrdata", exp, q);
   endtask
   task automatic flag_chk(input logic exp);
      chk("flag", {31'h0, exp}, {31'h0, stack_space_flag});
   endtask
   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   // ----------------
   // scenarios
   // ----------------
   task automatic t_stack();
      flag_chk(1'b1);
      for (int i = 0; i < 15; i++)
         cars_seq_model_i.do_push(16'hA000 + 16'(i));
      flag_chk(1'b0);
      chk("irq", 32'h0, {31'h0, irq});
      wr(32'h108, 32'h1);
      repeat (2) @(posedge hclk);
      chk("irq", 32'h1, {31'h0, irq});
      rd_chk(32'h104, 32'h1);
      repeat (2) @(posedge hclk);
      chk("irq", 32'h0, {31'h0, irq});
      wr(32'h108, 32'h0);
      cars_seq_model_i.do_pop();
      chk("pop_pc", 32'hA00E, {16'h0, pop_pc});
      flag_chk(1'b1);
      cars_seq_model_i.do_push(16'hA00E);
      for (int i = 0; i < 3; i++)
         cars_seq_model_i.do_push(16'hB000 + 16'(i));
      flag_chk(1'b0);
      for (int i = 2; i >= 0; i--) begin
         cars_seq_model_i.do_pop();
         chk("pop_pc", 32'hB000 + 32'(i), {16'h0, pop_pc});
      end
      flag_chk(1'b0);
      rd_chk(32'h100, 32'h0);
      rd_chk(32'h104, 32'h7);
      $display("test stack done");
   endtask
   task automatic t_underflow();
      do_reset();
      rd_chk(32'h100, 32'h1);
      cars_seq_model_i.do_pop();
      flag_chk(1'b0);
      cars_seq_model_i.do_push(16'h1234);
      cars_seq_model_i.do_pop();
      chk("pop_pc", 32'h1234, {16'h0, pop_pc});
      cars_seq_model_i.do_pop();
      flag_chk(1'b0);
      $display("test underflow done");
   endtask
   task automatic t_indirect();
      wr(32'h24, 32'h1A);
      wr(32'h20, 32'h5A);
      rd_chk(32'h20, 32'h5A);
      wr(32'h04, 32'h08);
      rd_chk(32'h00, 32'h0);
      rd_chk(32'h10C, 32'h1);
      wr(32'h04, 32'h1A);
      rd_chk(32'h00, 32'h5A);
      rd_chk(32'h10C, 32'h0);
      wr(32'h04, 32'h08);
      rd_chk(32'h00, 32'h0);
      wr(32'h00, 32'hFF);
      rd_chk(32'h10C, 32'h1);
      rd_chk(32'h20, 32'h5A);
      $display("test indirect done");
   endtask
   task automatic t_banks();
      wr(32'h24, 32'h20);
      wr(32'h3C, 32'h00);
      wr(32'h20, 32'h11);
      wr(32'h3C, 32'h10);
      wr(32'h20, 32'h22);
      wr(32'h3C, 32'h05);
      rd_chk(32'h20, 32'h11);
      wr(32'h3C, 32'h10);
      rd_chk(32'h20, 32'h22);
      wr(32'h3C, 32'h30);
      rd_chk(32'h20, 32'h0);
      rd_chk(32'h200, 32'h0);
      wr(32'h3C, 32'h01);
      wr(32'h40, 32'h33);
      wr(32'h3C, 32'h02);
      wr(32'h40, 32'h44);
      wr(32'h3C, 32'hF1);
      rd_chk(32'h40, 32'h33);
      wr(32'h3C, 32'h08);
      rd_chk(32'h40, 32'h0);
      rd_chk(32'h68, 32'h5A);
      $display("test banks done");
   endtask
   // ----------------
   // run control
   // ----------------
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      do_reset();
      t_stack();
      t_underflow();
      t_indirect();
      t_banks();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge hclk);
      n_errors++;
      stop_test();
   end
endmodule
bind cars_core cars_core_sva cars_core_sva_i (.hclk(hclk), .hresetn(hresetn), .push(push),
   .pop(pop), .push_pc(push_pc), .pop_pc(pop_pc), .stack_space_flag(stack_space_flag));

// ==== rtl/cars_core.sv ====
/*
 return-address stack and indirect / banked data addressing.
 assumes the sequencer gives single-cycle push and pop strobes, never both at once.
*/
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - sixteen by sixteen stack, push pc on calls
// - pop on return, literal or interrupt return
// - stack and pointer not software reachable
// - push and pop leave pc latch alone
// - circular stack, pointer zero on reset
// - flag set at reset, cleared at Fh
// - wrap Fh to 0 locks flag clear
// - pop first clears flag, then push locks
// - seventeenth push overwrites the first entry
// - windows unstored, access address in pointer
// - 8-bit pointers, banks from bank selector
// - indirect read of window returns zero, sets zero
// - indirect write of window is a no-operation
// - locations 10h-17h banked by low nibble
// - ram 20h-FFh banked by high nibble
// - unimplemented locations read as zeros
module cars_core (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // sequencer stack port
   input wire logic push,
   input wire logic pop,
   input wire logic [15:0] push_pc,
   output logic [15:0] pop_pc,
   output logic stack_space_flag,
   // interrupt
   output logic irq
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [15:0] stack_mem [cars_pkg::STACK_DEPTH];
   logic [7:0] sfr_mem [cars_pkg::SFR_BANKS][8];
   logic [7:0] gpr_mem [cars_pkg::GPR_BANKS][224];
   logic [7:0] gpr_flat [6];
   logic [3:0] stack_ptr;
   logic space_locked;
   logic any_op;
   logic pop_first;
   logic [7:0] pointer_zero;
   logic [7:0] pointer_one;
   logic [7:0] bank_selector;
   logic zero_flag;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [3:0] next_stack_ptr;
   // ----------------------------------------
   // bus address phase capture
   // ----------------------------------------
   logic dp_valid;
   logic dp_write;
   logic [7:0] dp_index;
   logic ap_valid;
   assign ap_valid = hsel && hready && (htrans == cars_pkg::HTRANS_NONSEQ);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_index <= 8'h00;
      end else begin
         dp_valid <= ap_valid;
         dp_write <= hwrite;
         dp_index <= haddr[9:2];
      end
   end
   // ----------------------------------------
   // data-space decode
   // ----------------------------------------
   function automatic logic is_window(input logic [7:0] a);
      is_window = (a == cars_pkg::IDX_INDIRECT_WINDOW_ZERO) ||
         (a == cars_pkg::IDX_INDIRECT_WINDOW_ONE);
   endfunction
   function automatic logic is_sfr_banked(input logic [7:0] a);
      is_sfr_banked = (a >= cars_pkg::SFR_BANKED_LO) && (a <= cars_pkg::SFR_BANKED_HI);
   endfunction
   function automatic logic is_gpr_banked(input logic [7:0] a);
      is_gpr_banked = (a >= cars_pkg::GPR_BANKED_LO);
   endfunction
   function automatic logic is_gpr_flat(input logic [7:0] a);
      is_gpr_flat = (a >= cars_pkg::GPR_UNBANKED_LO) && (a < cars_pkg::GPR_BANKED_LO);
   endfunction
   // resolve window accesses to the paired pointer's target
   logic [7:0] target;
   logic via_window;
   always_comb begin
      via_window = 1'b0;
      target = dp_index;
      if (dp_index == cars_pkg::IDX_INDIRECT_WINDOW_ZERO) begin
         target = pointer_zero;
         via_window = 1'b1;
      end else if (dp_index == cars_pkg::IDX_INDIRECT_WINDOW_ONE) begin
         target = pointer_one;
         via_window = 1'b1;
      end
   end
   logic [3:0] sfr_bank;
   logic [3:0] gpr_bank;
   logic [7:0] gpr_off;
   assign sfr_bank = bank_selector[3:0];
   assign gpr_bank = bank_selector[7:4];
   assign gpr_off = target - cars_pkg::GPR_BANKED_LO;
   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = cars_pkg::REG_RESET;
      if (via_window && is_window(target)) begin
         rd_byte = 8'h00;
      end else if (target == cars_pkg::IDX_POINTER_ZERO) begin
         rd_byte = pointer_zero;
      end else if (target == cars_pkg::IDX_POINTER_ONE) begin
         rd_byte = pointer_one;
      end else if (target == cars_pkg::IDX_BANK_SELECTOR) begin
         rd_byte = bank_selector;
      end else if (is_sfr_banked(target)) begin
         if (cars_pkg::SFR_BANKS_PRESENT[sfr_bank]) begin
            rd_byte = sfr_mem[sfr_bank][target[2:0]];
         end
      end else if (is_gpr_flat(target)) begin
         rd_byte = gpr_flat[target[2:0] - 3'h2];
      end else if (is_gpr_banked(target)) begin
         if (cars_pkg::GPR_BANKS_PRESENT[gpr_bank]) begin
            rd_byte = gpr_mem[gpr_bank][gpr_off];
         end
      end
   end
   logic wr_en;
   assign wr_en = dp_valid && dp_write && !(via_window && is_window(target));
   // data-space reads answer a cycle late: one wait state for them
   logic hold;
   assign hold = ap_valid && !hwrite && (haddr[9:2] < cars_pkg::IDX_STACK_STATUS);
   // ----------------------------------------
   // bus response
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= cars_pkg::RDATA_ZERO;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= !hold;
         hresp <= 1'b0;
         hrdata <= cars_pkg::RDATA_ZERO;
         if (ap_valid && !hwrite) begin
            unique case (haddr[9:2])
               cars_pkg::IDX_STACK_STATUS: hrdata <= {31'h0, stack_space_flag};
               cars_pkg::IDX_IRQ_STATUS: hrdata <= {29'h0, irq_status};
               cars_pkg::IDX_IRQ_MASK: hrdata <= {29'h0, irq_mask};
               cars_pkg::IDX_ZERO_FLAG: hrdata <= {31'h0, zero_flag};
               default: hrdata <= cars_pkg::RDATA_ZERO;
            endcase
         end else if (dp_valid && !dp_write && dp_index < cars_pkg::IDX_STACK_STATUS) begin
            hrdata <= {24'h0, rd_byte};
         end
      end
   end
   // ----------------------------------------
   // data-space registers
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pointer_zero <= cars_pkg::REG_RESET;
         pointer_one <= cars_pkg::REG_RESET;
         bank_selector <= cars_pkg::REG_RESET;
      end else if (wr_en) begin
         if (target == cars_pkg::IDX_POINTER_ZERO) begin
            pointer_zero <= hwdata[7:0];
         end
         if (target == cars_pkg::IDX_POINTER_ONE) begin
            pointer_one <= hwdata[7:0];
         end
         if (target == cars_pkg::IDX_BANK_SELECTOR) begin
            bank_selector <= hwdata[7:0];
         end
      end
   end
   always_ff @(posedge hclk) begin
      if (wr_en && is_sfr_banked(target) && cars_pkg::SFR_BANKS_PRESENT[sfr_bank]) begin
         sfr_mem[sfr_bank][target[2:0]] <= hwdata[7:0];
      end
      if (wr_en && is_gpr_flat(target)) begin
         gpr_flat[target[2:0] - 3'h2] <= hwdata[7:0];
      end
      if (wr_en && is_gpr_banked(target) && cars_pkg::GPR_BANKS_PRESENT[gpr_bank]) begin
         gpr_mem[gpr_bank][gpr_off] <= hwdata[7:0];
      end
   end
   // zero status of the last indirect read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         zero_flag <= 1'b0;
      end else if (dp_valid && !dp_write && via_window) begin
         zero_flag <= (rd_byte == 8'h00);
      end
   end
   // ----------------------------------------
   // return stack
   // ----------------------------------------
   always_comb begin
      next_stack_ptr = stack_ptr;
      if (push) begin
         next_stack_ptr = stack_ptr + 4'h1;
      end else if (pop) begin
         next_stack_ptr = stack_ptr - 4'h1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stack_ptr <= cars_pkg::STACK_PTR_RESET;
      end else begin
         stack_ptr <= next_stack_ptr;
      end
   end
   always_ff @(posedge hclk) begin
      if (push) begin
         stack_mem[stack_ptr] <= push_pc;
      end
   end
   // pc latch lives outside; stack traffic never touches it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pop_pc <= 16'h0000;
      end else if (pop && !push) begin
         pop_pc <= stack_mem[next_stack_ptr];
      end
   end
   // ----------------------------------------
   // stack space flag
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         space_locked <= 1'b0;
         any_op <= 1'b0;
         pop_first <= 1'b0;
      end else begin
         if (push || pop) begin
            any_op <= 1'b1;
         end
         if (pop && !any_op) begin
            pop_first <= 1'b1;
         end else if (pop) begin
            pop_first <= 1'b0;
         end
         if (push && stack_ptr == cars_pkg::STACK_PTR_TOP) begin
            space_locked <= 1'b1;
         end
         if (push && pop_first) begin
            space_locked <= 1'b1;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stack_space_flag <= 1'b1;
      end else begin
         stack_space_flag <= !space_locked && !(push && stack_ptr == cars_pkg::STACK_PTR_TOP)
            && (next_stack_ptr != cars_pkg::STACK_PTR_TOP) && !(push && pop_first);
      end
   end
   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   logic [2:0] irq_set;
   logic irq_rd_clr;
   assign irq_set[cars_pkg::IRQ_BIT_SPACE_LOST] = stack_space_flag &&
      (next_stack_ptr == cars_pkg::STACK_PTR_TOP);
   assign irq_set[cars_pkg::IRQ_BIT_WRAP] = push && stack_ptr == cars_pkg::STACK_PTR_TOP;
   assign irq_set[cars_pkg::IRQ_BIT_UNDERFLOW] = pop && stack_ptr == cars_pkg::STACK_PTR_RESET;
   assign irq_rd_clr = ap_valid && !hwrite && haddr[9:2] == cars_pkg::IDX_IRQ_STATUS;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= 3'h0;
      end else begin
         irq_status <= (irq_rd_clr ? 3'h0 : irq_status) | irq_set;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= 3'h0;
      end else if (dp_valid && dp_write && dp_index == cars_pkg::IDX_IRQ_MASK) begin
         irq_mask <= hwdata[2:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_rd_clr ? 3'h0 : irq_status) | irq_set) & irq_mask);
      end
   end
endmodule

// ==== rtl/cars_pkg.sv ====
/*
 constants for the core addressing and return stack block.
 assumes an ahb-lite register port with 32-bit data, one word per register.
*/
package cars_pkg;
   // ----------------------------------------
   // register map (byte addresses = index*4)
   // ----------------------------------------
   localparam logic [7:0] IDX_INDIRECT_WINDOW_ZERO = 8'h00;
   localparam logic [7:0] IDX_POINTER_ZERO = 8'h01;
   localparam logic [7:0] IDX_INDIRECT_WINDOW_ONE = 8'h08;
   localparam logic [7:0] IDX_POINTER_ONE = 8'h09;
   localparam logic [7:0] IDX_BANK_SELECTOR = 8'h0F;
   localparam logic [7:0] IDX_STACK_STATUS = 8'h40;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h41;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h42;
   localparam logic [7:0] IDX_ZERO_FLAG = 8'h43;
   // ----------------------------------------
   // data space layout
   // ----------------------------------------
   localparam logic [7:0] SFR_BANKED_LO = 8'h10;
   localparam logic [7:0] SFR_BANKED_HI = 8'h17;
   localparam logic [7:0] GPR_UNBANKED_LO = 8'h1A;
   localparam logic [7:0] GPR_BANKED_LO = 8'h20;
   localparam int SFR_BANKS = 16;
   localparam int GPR_BANKS = 16;
   localparam logic [15:0] GPR_BANKS_PRESENT = 16'h0007;
   localparam logic [15:0] SFR_BANKS_PRESENT = 16'h00FF;
   // ----------------------------------------
   // stack and reset values
   // ----------------------------------------
   localparam int STACK_DEPTH = 16;
   localparam logic [3:0] STACK_PTR_RESET = 4'h0;
   localparam logic [3:0] STACK_PTR_TOP = 4'hF;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ----------------------------------------
   // interrupt status bit positions
   // ----------------------------------------
   localparam int IRQ_BIT_SPACE_LOST = 0;
   localparam int IRQ_BIT_WRAP = 1;
   localparam int IRQ_BIT_UNDERFLOW = 2;
   localparam int IRQ_WIDTH = 3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage
